// ==== hw/ccrfs_map.svh ====
`ifndef CCRFS_MAP_SVH
`define CCRFS_MAP_SVH
`define CCRFS_ADDR_PTR1 8'h80
`define CCRFS_ADDR_PTR2 8'h81
`define CCRFS_ADDR_SLOT1 8'h82
`define CCRFS_ADDR_SLOT2 8'h83
`define CCRFS_ADDR_SUM 8'hFF
`define CCRFS_RESET_VEC 12'hFFE
`define CCRFS_NMI_VEC 12'hFFC
`define CCRFS_CORE_DIV 4'hD
`define CCRFS_PERIPH_DIV 4'hC
`define CCRFS_STACK_DEPTH 6
`define CCRFS_REG_RST 8'h00
`endif

// ==== hw/ccrfs_pkg.sv ====
package ccrfs_pkg;
  typedef enum logic [1:0] {
    CCRFS_CTX_NORM,
    CCRFS_CTX_IRQ,
    CCRFS_CTX_NMI
  } ccrfs_ctx_t;
  typedef enum logic [2:0] {
    CCRFS_PC_HOLD,
    CCRFS_PC_INC,
    CCRFS_PC_REL,
    CCRFS_PC_LOAD,
    CCRFS_PC_IRQ,
    CCRFS_PC_NMI,
    CCRFS_PC_RET,
    CCRFS_PC_IRQ_BACK_INSTR
  } ccrfs_pc_op_t;
  typedef enum logic [2:0] {
    CCRFS_ALU_NONE,
    CCRFS_ALU_ARITH,
    CCRFS_ALU_LOGIC,
    CCRFS_ALU_BTEST,
    CCRFS_ALU_ROTL
  } ccrfs_alu_op_t;
endpackage

// ==== hw/ccrfs_stack_if.sv ====
`timescale 1ns/1ns
interface ccrfs_stack_if;
  logic push;
  logic pop;
  logic [11:0] push_data;
  logic [11:0] top_data;
  logic empty;
  logic full;
  modport core (output push, output pop, output push_data, input top_data, input empty, input full);
  modport stack (input push, input pop, input push_data, output top_data, output empty, output full);
endinterface

// ==== hw/ccrfs_stack.sv ====
`timescale 1ns/1ns
`include "ccrfs_map.svh"
module ccrfs_stack
  import ccrfs_pkg::*;
(
  input wire logic i_clk,        // Core clock
  input wire logic i_rst_b,      // Sync reset, active low
  ccrfs_stack_if.stack bus       // Push/pop port
);
  logic [11:0] lvl_reg [`CCRFS_STACK_DEPTH];
  logic [11:0] lvl_next [`CCRFS_STACK_DEPTH];
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic full_reg, full_next, empty_reg, empty_next;

  always_comb begin
    lvl_next = lvl_reg;
    cnt_next = cnt_reg;
    if (bus.push) begin
      for (int i = `CCRFS_STACK_DEPTH - 1; i > 0; i--) begin
        lvl_next[i] = lvl_reg[i-1];
      end
      lvl_next[0] = bus.push_data;
      // Depth saturates, oldest address falls off the bottom
      if (cnt_reg != 3'(`CCRFS_STACK_DEPTH)) begin
        cnt_next = cnt_reg + 3'h1;
      end
    end else if (bus.pop && cnt_reg != 3'h0) begin
      for (int i = 0; i < `CCRFS_STACK_DEPTH - 1; i++) begin
        lvl_next[i] = lvl_reg[i+1];
      end
      cnt_next = cnt_reg - 3'h1;
    end
    // Status is registered so the core can hand it out straight from a flip-flop
    full_next = (cnt_next == 3'(`CCRFS_STACK_DEPTH));
    empty_next = (cnt_next == 3'h0);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_reg <= 3'h0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
      for (int i = 0; i < `CCRFS_STACK_DEPTH; i++) begin
        lvl_reg[i] <= 12'h000;
      end
    end else begin
      cnt_reg <= cnt_next;
      full_reg <= full_next;
      empty_reg <= empty_next;
      lvl_reg <= lvl_next;
    end
  end

  assign bus.top_data = lvl_reg[0];
  assign bus.empty = empty_reg;
  assign bus.full = full_reg;

  property p_push_top;
    @(posedge i_clk) disable iff (!i_rst_b)
      bus.push |=> lvl_reg[0] == $past(bus.push_data);
  endproperty
  a_push_top: assert property (p_push_top) else $error("stack top not loaded on push");

  property p_pop_shift;
    @(posedge i_clk) disable iff (!i_rst_b)
      (bus.pop && !bus.push && cnt_reg != 3'h0) |=> lvl_reg[0] == $past(lvl_reg[1]);
  endproperty
  a_pop_shift: assert property (p_pop_shift) else $error("stack not shifted up on pop");

  property p_full_sat;
    @(posedge i_clk) disable iff (!i_rst_b)
      (bus.push && bus.full) |=> bus.full;
  endproperty
  a_full_sat: assert property (p_full_sat) else $error("stack depth left deepest position");
endmodule // ccrfs_stack

// ==== hw/ccrfs_core.sv ====
//------------------------------------------------------------
//------------------------------------------------------------
`timescale 1ns/1ns
`include "ccrfs_map.svh"
module ccrfs_core
  import ccrfs_pkg::*;
(
  input wire logic i_clk,                // Internal clock
  input wire logic i_rst_b,              // Chip reset, sync, active low
  input wire logic i_dwr,                // Data-space write strobe
  input wire logic [7:0] i_daddr,        // Data-space address
  input wire logic [7:0] i_dwdata,       // Data-space write data
  output logic [7:0] o_drdata,           // Read data, registered
  output logic o_dhit,                   // Address maps to a core register
  input wire ccrfs_pc_op_t i_pc_op,      // Counter update source
  input wire logic [11:0] i_pc_target,   // Jump/call/vector target
  input wire logic [7:0] i_rel_off,      // Signed relative offset
  input wire logic i_call,               // Push counter with the load
  input wire ccrfs_alu_op_t i_alu_op,    // Flag update kind
  input wire logic [7:0] i_alu_res,      // Result of operation
  input wire logic i_alu_carry,          // Carry/borrow/tested/rotated bit
  input wire logic [2:0] i_instr_cyc,    // Machine cycles of instruction
  output logic [11:0] o_pc,              // Program counter
  output logic o_carry,                  // Carry of active context
  output logic o_zero,                   // Zero of active context
  output logic [1:0] o_ctx,              // Active context
  output logic o_core_en,                // Machine cycle enable
  output logic o_periph_en,              // Peripheral clock enable
  output logic o_instr_done,             // Instruction completed
  output logic o_stack_full              // Stack at deepest position
);
  //------------------------------------------------------------
  // Dividers
  //------------------------------------------------------------
  logic [3:0] cdiv_reg, cdiv_next, pdiv_reg, pdiv_next;
  logic core_en_reg, core_en_next, periph_en_reg, periph_en_next;

  function automatic logic [3:0] div_step(input logic [3:0] v, input logic [3:0] n);
    div_step = (v == n - 4'h1) ? 4'h0 : v + 4'h1;
  endfunction

  always_comb begin
    cdiv_next = div_step(cdiv_reg, `CCRFS_CORE_DIV);
    pdiv_next = div_step(pdiv_reg, `CCRFS_PERIPH_DIV);
    core_en_next = (cdiv_reg == `CCRFS_CORE_DIV - 4'h1);
    periph_en_next = (pdiv_reg == `CCRFS_PERIPH_DIV - 4'h1);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cdiv_reg <= 4'h0;
      pdiv_reg <= 4'h0;
      core_en_reg <= 1'b0;
      periph_en_reg <= 1'b0;
    end else begin
      cdiv_reg <= cdiv_next;
      pdiv_reg <= pdiv_next;
      core_en_reg <= core_en_next;
      periph_en_reg <= periph_en_next;
    end
  end

  //------------------------------------------------------------
  // Data-space registers
  //------------------------------------------------------------
  logic [7:0] sum_register_reg, pointer_one_reg, pointer_two_reg;
  logic [7:0] short_slot_first_reg, short_slot_second_reg;
  logic [7:0] sum_register_next, pointer_one_next, pointer_two_next;
  logic [7:0] short_slot_first_next, short_slot_second_next;
  logic [7:0] drdata_next;
  logic dhit_next;

  // Software must save these itself; no hardware context save
  always_comb begin
    sum_register_next = sum_register_reg;
    pointer_one_next = pointer_one_reg;
    pointer_two_next = pointer_two_reg;
    short_slot_first_next = short_slot_first_reg;
    short_slot_second_next = short_slot_second_reg;
    drdata_next = 8'h00;
    dhit_next = 1'b1;
    if (i_daddr == `CCRFS_ADDR_SUM) begin
      drdata_next = sum_register_reg;
      if (i_dwr) sum_register_next = i_dwdata;
    end else if (i_daddr == `CCRFS_ADDR_PTR1) begin
      drdata_next = pointer_one_reg;
      if (i_dwr) pointer_one_next = i_dwdata;
    end else if (i_daddr == `CCRFS_ADDR_PTR2) begin
      drdata_next = pointer_two_reg;
      if (i_dwr) pointer_two_next = i_dwdata;
    end else if (i_daddr == `CCRFS_ADDR_SLOT1) begin
      drdata_next = short_slot_first_reg;
      if (i_dwr) short_slot_first_next = i_dwdata;
    end else if (i_daddr == `CCRFS_ADDR_SLOT2) begin
      drdata_next = short_slot_second_reg;
      if (i_dwr) short_slot_second_next = i_dwdata;
    end else begin
      dhit_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sum_register_reg <= `CCRFS_REG_RST;
      pointer_one_reg <= `CCRFS_REG_RST;
      pointer_two_reg <= `CCRFS_REG_RST;
      short_slot_first_reg <= `CCRFS_REG_RST;
      short_slot_second_reg <= `CCRFS_REG_RST;
      o_drdata <= 8'h00;
      o_dhit <= 1'b0;
    end else begin
      sum_register_reg <= sum_register_next;
      pointer_one_reg <= pointer_one_next;
      pointer_two_reg <= pointer_two_next;
      short_slot_first_reg <= short_slot_first_next;
      short_slot_second_reg <= short_slot_second_next;
      o_drdata <= drdata_next;
      o_dhit <= dhit_next;
    end
  end

  //------------------------------------------------------------
  // Program counter, context and flags
  //------------------------------------------------------------
  ccrfs_stack_if stk ();
  ccrfs_stack u_stack (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .bus(stk.stack)
  );

  logic [11:0] pc_reg, pc_next;
  ccrfs_ctx_t ctx_reg, ctx_next;
  // Resume chain: NMI can preempt interrupt which preempts normal
  ccrfs_ctx_t res1_reg, res1_next, res2_reg, res2_next;
  logic [2:0] cflag_reg, cflag_next, zflag_reg, zflag_next;
  logic push_c, pop_c;
  logic [2:0] mcyc_reg, mcyc_next;
  logic done_next, done_reg;
  logic carry_out_reg, carry_out_next, zero_out_reg, zero_out_next;

  always_comb begin
    pc_next = pc_reg;
    ctx_next = ctx_reg;
    res1_next = res1_reg;
    res2_next = res2_reg;
    push_c = 1'b0;
    pop_c = 1'b0;
    if (core_en_reg) begin
      case (i_pc_op)
        CCRFS_PC_INC: pc_next = pc_reg + 12'h001;
        CCRFS_PC_REL: pc_next = pc_reg + {{4{i_rel_off[7]}}, i_rel_off};
        CCRFS_PC_LOAD: begin
          pc_next = i_pc_target;
          push_c = i_call;
        end
        CCRFS_PC_IRQ, CCRFS_PC_NMI: begin
          pc_next = (i_pc_op == CCRFS_PC_NMI) ? `CCRFS_NMI_VEC : i_pc_target;
          push_c = 1'b1;
          res2_next = res1_reg;
          res1_next = ctx_reg;
          ctx_next = (i_pc_op == CCRFS_PC_NMI) ? CCRFS_CTX_NMI : CCRFS_CTX_IRQ;
        end
        CCRFS_PC_RET, CCRFS_PC_IRQ_BACK_INSTR: begin
          pop_c = 1'b1;
          pc_next = stk.empty ? pc_reg + 12'h001 : stk.top_data;
          if (i_pc_op == CCRFS_PC_IRQ_BACK_INSTR) begin
            ctx_next = res1_reg;
            res1_next = res2_reg;
            res2_next = CCRFS_CTX_NORM;
          end
        end
        default: pc_next = pc_reg;
      endcase
    end
  end

  // Only the active pair is touched, others keep their value
  always_comb begin
    cflag_next = cflag_reg;
    zflag_next = zflag_reg;
    if (core_en_reg && i_alu_op != CCRFS_ALU_NONE) begin
      if (i_alu_op != CCRFS_ALU_LOGIC) cflag_next[ctx_reg] = i_alu_carry;
      if (i_alu_op == CCRFS_ALU_ARITH || i_alu_op == CCRFS_ALU_LOGIC) begin
        zflag_next[ctx_reg] = (i_alu_res == 8'h00);
      end
    end
    // Active pair is selected ahead of the edge so the flag outputs leave a flip-flop
    carry_out_next = cflag_next[ctx_next];
    zero_out_next = zflag_next[ctx_next];
  end

  always_comb begin
    mcyc_next = mcyc_reg;
    done_next = 1'b0;
    if (core_en_reg) begin
      if (mcyc_reg + 3'h1 >= i_instr_cyc) begin
        mcyc_next = 3'h0;
        done_next = 1'b1;
      end else begin
        mcyc_next = mcyc_reg + 3'h1;
      end
    end
  end

  assign stk.push = push_c;
  assign stk.pop = pop_c;
  assign stk.push_data = pc_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pc_reg <= `CCRFS_RESET_VEC;
      ctx_reg <= CCRFS_CTX_NMI;
      res1_reg <= CCRFS_CTX_NORM;
      res2_reg <= CCRFS_CTX_NORM;
      cflag_reg <= 3'h0;
      zflag_reg <= 3'h0;
      mcyc_reg <= 3'h0;
      done_reg <= 1'b0;
      carry_out_reg <= 1'b0;
      zero_out_reg <= 1'b0;
    end else begin
      pc_reg <= pc_next;
      ctx_reg <= ctx_next;
      res1_reg <= res1_next;
      res2_reg <= res2_next;
      cflag_reg <= cflag_next;
      zflag_reg <= zflag_next;
      mcyc_reg <= mcyc_next;
      done_reg <= done_next;
      carry_out_reg <= carry_out_next;
      zero_out_reg <= zero_out_next;
    end
  end

  always_comb begin
    o_pc = pc_reg;
    o_carry = carry_out_reg;
    o_zero = zero_out_reg;
    o_ctx = ctx_reg;
    o_core_en = core_en_reg;
    o_periph_en = periph_en_reg;
    o_instr_done = done_reg;
    o_stack_full = stk.full;
  end

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  sequence s_inc_step;
    core_en_reg && i_pc_op == CCRFS_PC_INC;
  endsequence
  property p_pc_inc;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_inc_step |=> pc_reg == $past(pc_reg) + 12'h001;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("counter did not step by one");

  property p_core_div;
    @(posedge i_clk) disable iff (!i_rst_b)
      core_en_reg |=> !core_en_reg [*8] ##1 !core_en_reg [*4] ##1 core_en_reg;
  endproperty
  a_core_div: assert property (p_core_div) else $error("core enable not every 13 clocks");

  property p_periph_div;
    @(posedge i_clk) disable iff (!i_rst_b)
      periph_en_reg |=> !periph_en_reg [*8] ##1 !periph_en_reg [*3] ##1 periph_en_reg;
  endproperty
  a_periph_div: assert property (p_periph_div) else $error("peripheral enable not every 12 clocks");

  property p_nmi_entry;
    @(posedge i_clk) disable iff (!i_rst_b)
      (core_en_reg && i_pc_op == CCRFS_PC_NMI) |=> ctx_reg == CCRFS_CTX_NMI && pc_reg == `CCRFS_NMI_VEC;
  endproperty
  a_nmi_entry: assert property (p_nmi_entry) else $error("NMI entry wrong context or vector");

  property p_irq_back_instr_restore;
    @(posedge i_clk) disable iff (!i_rst_b)
      (core_en_reg && i_pc_op == CCRFS_PC_IRQ_BACK_INSTR) |=> ctx_reg == $past(res1_reg);
  endproperty
  a_irq_back_instr_restore: assert property (p_irq_back_instr_restore) else $error("return did not restore context");

  property p_other_pairs_kept;
    @(posedge i_clk) disable iff (!i_rst_b)
      ##1 ($past(ctx_reg) != CCRFS_CTX_NORM) |-> cflag_reg[0] == $past(cflag_reg[0]);
  endproperty
  a_other_pairs_kept: assert property (p_other_pairs_kept) else $error("inactive flag pair changed");

  property p_zero_set;
    @(posedge i_clk) disable iff (!i_rst_b)
      (core_en_reg && i_alu_op == CCRFS_ALU_ARITH && i_pc_op inside {CCRFS_PC_HOLD, CCRFS_PC_INC})
        |=> o_zero == ($past(i_alu_res) == 8'h00);
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("zero flag wrong after operation");

  property p_empty_ret;
    @(posedge i_clk) disable iff (!i_rst_b)
      (core_en_reg && i_pc_op == CCRFS_PC_RET && stk.empty) |=> pc_reg == $past(pc_reg) + 12'h001;
  endproperty
  a_empty_ret: assert property (p_empty_ret) else $error("empty return not sequential");

  property p_ret_pop;
    @(posedge i_clk) disable iff (!i_rst_b)
      (core_en_reg && i_pc_op == CCRFS_PC_RET && !stk.empty) |=> pc_reg == $past(stk.top_data);
  endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("return did not pop stack");
endmodule // ccrfs_core

// ==== sim/ccrfs_pmem.sv ====
`timescale 1ns/1ns
module ccrfs_pmem (
  input wire logic [11:0] i_addr, // Fetch address
  output logic [7:0] o_byte       // Byte at that address
);
  // Fixed pattern stands in for a programmed image; every byte differs from its neighbours
  assign o_byte = i_addr[7:0] ^ {i_addr[11:8], 4'h5};
endmodule // ccrfs_pmem

// ==== sim/ccrfs_core_bench.sv ====
`timescale 1ns/1ns
`include "ccrfs_map.svh"
module ccrfs_core_bench import ccrfs_pkg::*; ;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_dwr = 1'b0;
  logic i_call = 1'b0;
  logic i_alu_carry = 1'b0;
  logic [7:0] i_daddr = 8'h00;
  logic [7:0] i_dwdata = 8'h00;
  logic [7:0] i_alu_res = 8'h00;
  logic [11:0] i_pc_target = 12'h000;
  logic [2:0] i_instr_cyc = 3'h2;
  ccrfs_pc_op_t i_pc_op = CCRFS_PC_HOLD;
  ccrfs_alu_op_t i_alu_op = CCRFS_ALU_NONE;
  logic [7:0] o_drdata, rel_off;
  logic [11:0] o_pc;
  logic [1:0] o_ctx;
  logic o_dhit, o_carry, o_zero, o_core_en, o_periph_en, o_instr_done, o_stack_full;
  logic chk_req = 1'b0;
  logic [17:0] notes[$];
  logic [17:0] note_q;
  logic [11:0] m_pc = `CCRFS_RESET_VEC;
  logic [1:0] m_ctx = 2'h2;
  logic [2:0] m_c = 3'h0;
  logic [2:0] m_z = 3'h0;
  logic [11:0] stk[$];
  logic [1:0] back[$];
  logic [7:0] addrs[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
  logic [7:0] vals[5];
  int n_errors = 0;
  int compares = 0;
  integer seed = 32'h7393;

  always #25 i_clk = ~i_clk;

  ccrfs_pmem u_mem (.i_addr(o_pc), .o_byte(rel_off));

  ccrfs_core u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_dwr(i_dwr), .i_daddr(i_daddr), .i_dwdata(i_dwdata),
    .o_drdata(o_drdata), .o_dhit(o_dhit), .i_pc_op(i_pc_op), .i_pc_target(i_pc_target), .i_rel_off(rel_off),
    .i_call(i_call), .i_alu_op(i_alu_op), .i_alu_res(i_alu_res), .i_alu_carry(i_alu_carry),
    .i_instr_cyc(i_instr_cyc), .o_pc(o_pc), .o_carry(o_carry), .o_zero(o_zero), .o_ctx(o_ctx),
    .o_core_en(o_core_en), .o_periph_en(o_periph_en), .o_instr_done(o_instr_done), .o_stack_full(o_stack_full));

  // ----------------------------------------
  // Compare tasks and result monitor
  // ----------------------------------------
  task automatic cmp_data(input logic [8:0] e);
    compares++;
    if ({o_dhit, o_drdata} !== e) begin
      n_errors++;
      $display("Error data_read exp %h got %h", e, {o_dhit, o_drdata});
    end
  endtask

  task automatic cmp_core(input logic [16:0] e);
    compares++;
    if ({o_stack_full, o_ctx, o_carry, o_zero, o_pc} !== e) begin
      n_errors++;
      $display("Error core_state exp %h got %h", e, {o_stack_full, o_ctx, o_carry, o_zero, o_pc});
    end
  endtask

  task automatic cmp_gap(input int e, input int g);
    compares++;
    if (g != e) begin
      n_errors++;
      $display("Error pulse_gap exp %0d got %0d", e, g);
    end
  endtask

  // Sampled at the falling edge, half a cycle after the registered outputs settle
  always @(negedge i_clk) begin
    if (chk_req === 1'b1) begin
      note_q = notes.pop_front();
      if (note_q[17]) cmp_core(note_q[16:0]);
      else cmp_data(note_q[8:0]);
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic note(input logic [17:0] n);
    notes.push_back(n);
    chk_req <= 1'b1;
    @(posedge i_clk);
    chk_req <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_daddr <= a;
    i_dwdata <= d;
    i_dwr <= 1'b1;
    @(posedge i_clk);
    i_dwr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    @(posedge i_clk);
    i_daddr <= a;
    @(posedge i_clk);
    note({9'h000, e});
  endtask

  task automatic push_pc();
    if (stk.size() == 6) void'(stk.pop_back());
    stk.push_front(m_pc);
  endtask

  // Request stands from a rising edge until the machine-cycle edge takes it; earlier edges must ignore it
  task automatic mc(input ccrfs_pc_op_t op, input logic [11:0] t, input logic cl, input ccrfs_alu_op_t a,
                    input logic [7:0] r, input logic cy);
    int k;
    @(posedge i_clk);
    i_pc_op <= op;
    i_pc_target <= t;
    i_call <= cl;
    i_alu_op <= a;
    i_alu_res <= r;
    i_alu_carry <= cy;
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (o_core_en !== 1'b1 && k < 20);
    // Flags belong to the context in force before the op switches it
    if (a == CCRFS_ALU_ARITH || a == CCRFS_ALU_BTEST || a == CCRFS_ALU_ROTL) m_c[m_ctx] = cy;
    if (a == CCRFS_ALU_ARITH || a == CCRFS_ALU_LOGIC) m_z[m_ctx] = (r == 8'h00);
    case (op)
      CCRFS_PC_INC: m_pc = m_pc + 12'h001;
      CCRFS_PC_REL: m_pc = m_pc + {{4{rel_off[7]}}, rel_off};
      CCRFS_PC_LOAD: begin
        if (cl) push_pc();
        m_pc = t;
      end
      CCRFS_PC_IRQ, CCRFS_PC_NMI: begin
        push_pc();
        back.push_front(m_ctx);
        m_pc = (op == CCRFS_PC_IRQ) ? t : `CCRFS_NMI_VEC;
        m_ctx = (op == CCRFS_PC_IRQ) ? 2'h1 : 2'h2;
      end
      CCRFS_PC_RET, CCRFS_PC_IRQ_BACK_INSTR: begin
        m_pc = (stk.size() != 0) ? stk.pop_front() : m_pc + 12'h001;
        if (op == CCRFS_PC_IRQ_BACK_INSTR) m_ctx = (back.size() != 0) ? back.pop_front() : 2'h0;
      end
      default: ;
    endcase
    @(posedge i_clk);
    i_pc_op <= CCRFS_PC_HOLD;
    i_alu_op <= CCRFS_ALU_NONE;
    i_call <= 1'b0;
    note({1'b1, stk.size() == 6, m_ctx, m_c[m_ctx], m_z[m_ctx], m_pc});
  endtask

  task automatic gap(input int s, input int e);
    int g;
    int n;
    g = 0;
    n = 0;
    while (n < 2 && g < 200) begin
      @(negedge i_clk);
      if (n != 0) g++;
      if ((s == 0 ? o_core_en : s == 1 ? o_periph_en : o_instr_done) === 1'b1) n++;
    end
    cmp_gap(e, g);
  endtask

  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    note({1'b1, 1'b0, 2'h2, 1'b0, 1'b0, `CCRFS_RESET_VEC});
    $display("test reset done");
    foreach (addrs[i]) rd(addrs[i], {1'b1, `CCRFS_REG_RST});
    foreach (addrs[i]) begin
      vals[i] = 8'($random(seed));
      wr(addrs[i], vals[i]);
    end
    wr(8'h84, 8'hA5);
    foreach (addrs[i]) rd(addrs[i], {1'b1, vals[i]});
    rd(8'h84, 9'h000);
    $display("test registers done");
    mc(CCRFS_PC_INC, 12'h000, 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    mc(CCRFS_PC_REL, 12'h000, 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    mc(CCRFS_PC_LOAD, 12'($random(seed)), 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    mc(CCRFS_PC_REL, 12'h000, 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    mc(CCRFS_PC_LOAD, 12'h880, 1'b1, CCRFS_ALU_NONE, 8'h00, 1'b0);
    mc(CCRFS_PC_RET, 12'h000, 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    $display("test counter done");
    mc(CCRFS_PC_HOLD, 12'h000, 1'b0, CCRFS_ALU_ARITH, 8'h00, 1'b1);
    mc(CCRFS_PC_IRQ_BACK_INSTR, 12'h000, 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    mc(CCRFS_PC_INC, 12'h000, 1'b0, CCRFS_ALU_LOGIC, 8'h05, 1'b1);
    mc(CCRFS_PC_INC, 12'h000, 1'b0, CCRFS_ALU_BTEST, 8'h00, 1'b1);
    mc(CCRFS_PC_IRQ, 12'hFF0, 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    mc(CCRFS_PC_HOLD, 12'h000, 1'b0, CCRFS_ALU_ROTL, 8'h00, 1'b1);
    mc(CCRFS_PC_HOLD, 12'h000, 1'b0, CCRFS_ALU_ARITH, 8'h40, 1'b0);
    mc(CCRFS_PC_NMI, 12'h000, 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    mc(CCRFS_PC_IRQ_BACK_INSTR, 12'h000, 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    mc(CCRFS_PC_IRQ_BACK_INSTR, 12'h000, 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    $display("test flags done");
    for (int i = 0; i < 7; i++) mc(CCRFS_PC_LOAD, 12'($random(seed)), 1'b1, CCRFS_ALU_NONE, 8'h00, 1'b0);
    for (int i = 0; i < 7; i++) mc(CCRFS_PC_RET, 12'h000, 1'b0, CCRFS_ALU_NONE, 8'h00, 1'b0);
    foreach (addrs[i]) rd(addrs[i], {1'b1, vals[i]});
    $display("test stack done");
    gap(0, `CCRFS_CORE_DIV);
    gap(1, `CCRFS_PERIPH_DIV);
    foreach (addrs[i]) begin
      if (i < 3) begin
        @(posedge i_clk);
        i_instr_cyc <= (i == 0) ? 3'h2 : (i == 1) ? 3'h4 : 3'h5;
        gap(2, ((i == 0) ? 2 : (i == 1) ? 4 : 5) * `CCRFS_CORE_DIV);
      end
    end
    $display("test timing done");
    tally_and_finish();
  end

  initial begin
    #(50 * 20000);
    n_errors++;
    tally_and_finish();
  end
endmodule // ccrfs_core_bench
